// file: include/bwd_pkg.sv
/*
  Constants for the board watchdog: shared-RAM offsets, field positions,
  reset values and tick counts.
  Assumes a 100 MHz clock and a byte-wide shared-RAM access port.
*/
package bwd_pkg;
  localparam logic [7:0]  BWD_OFS_CONFIG     = 8'h06;
  localparam logic [7:0]  BWD_OFS_MINUTES    = 8'h07;
  localparam logic [7:0]  BWD_OFS_SECONDS    = 8'h08;
  localparam int          BWD_BIT_RUN        = 0;
  localparam int          BWD_BIT_UNIT       = 1;
  localparam logic [7:0]  BWD_CONFIG_MASK    = 8'h03;
  localparam logic [7:0]  BWD_RESET_CONFIG   = 8'h00;
  localparam logic [7:0]  BWD_RESET_COUNT    = 8'h00;
  localparam logic [5:0]  BWD_RESET_SUBCOUNT = 6'h00;
  localparam logic [7:0]  BWD_RESET_PULSE    = 8'h00;
  localparam int          BWD_CLK_HZ         = 100000000;
  localparam int          BWD_TICK_S         = 1;
  localparam int          BWD_TICK_CYCLES    = BWD_CLK_HZ * BWD_TICK_S;
  localparam logic [5:0]  BWD_SEC_PER_MIN    = 6'h3c;
  localparam int          BWD_BOARD_RST_US   = 1;
  localparam int          BWD_BOARD_RST_CYC  = (BWD_BOARD_RST_US * BWD_CLK_HZ) / 1000000;
endpackage : bwd_pkg

// file: verilog/bwd_tick.sv
/*
  One-second tick generator: a single-cycle pulse every tick_cycles clocks.
  Assumes synchronous active-low reset; clear restarts the second.
*/
`timescale 1ns/1ps
`default_nettype none
module bwd_tick
  import bwd_pkg::*;
#(
  parameter int TICK_CYCLES = BWD_TICK_CYCLES
) (
  input  wire logic ref_clk_in,
  input  wire logic resetn_in,
  input  wire logic clear_in,
  output logic      tick_out
);
  logic [31:0] count;
  logic [31:0] next_count;
  logic        next_tick;

  always_comb begin
    next_count = count + 32'h1;
    next_tick  = 1'b0;
    if (clear_in) begin
      next_count = 32'h0;
    end else if (count >= 32'(TICK_CYCLES - 1)) begin
      next_count = 32'h0;
      next_tick  = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      count    <= 32'h0;
      tick_out <= 1'b0;
    end else begin
      count    <= next_count;
      tick_out <= next_tick;
    end
  end
endmodule : bwd_tick
`default_nettype wire

// file: verilog/bwd_watchdog.sv
/*
  Board watchdog: three shared-RAM byte registers, a seconds/minutes
  countdown and a board reset pulse.
  Assumes the embedded controller's 62/66 port handler turns host
  accesses into single-cycle byte read/write strobes on this port.
*/
`timescale 1ns/1ps
`default_nettype none
module bwd_watchdog
  import bwd_pkg::*;
#(
  parameter int TICK_CYCLES = BWD_TICK_CYCLES,
  parameter int RST_CYCLES  = (BWD_BOARD_RST_CYC < 1) ? 1 : BWD_BOARD_RST_CYC
) (
  input  wire logic       ref_clk_in,
  input  wire logic       resetn_in,
  input  wire logic [7:0] ram_addr_in,
  input  wire logic       ram_wr_in,
  input  wire logic       ram_rd_in,
  input  wire logic [7:0] ram_wdata_in,
  output logic      [7:0] ram_rdata_out,
  output logic            ram_rvalid_out,
  output logic            board_reset_out,
  output logic            countdown_active_out
);
  logic [7:0] watchdog_config;
  logic [7:0] minutes_countdown;
  logic [7:0] seconds_countdown;
  logic [5:0] sec_in_min;
  logic [7:0] rst_count;
  logic [7:0] next_config;
  logic [7:0] next_minutes;
  logic [7:0] next_seconds;
  logic [5:0] next_sec_in_min;
  logic [7:0] next_rst_count;
  logic [7:0] next_rdata;
  logic       next_rvalid;
  logic       next_board_reset;
  logic       next_active;
  logic       tick;
  logic       countdown_run;
  logic       count_unit_select;
  logic       wr_config;
  logic       wr_minutes;
  logic       wr_seconds;
  logic       restart;
  logic [7:0] active_count;

  assign countdown_run     = watchdog_config[BWD_BIT_RUN];
  assign count_unit_select = watchdog_config[BWD_BIT_UNIT];
  assign wr_config  = ram_wr_in && (ram_addr_in == BWD_OFS_CONFIG);
  assign wr_minutes = ram_wr_in && (ram_addr_in == BWD_OFS_MINUTES);
  assign wr_seconds = ram_wr_in && (ram_addr_in == BWD_OFS_SECONDS);
  // second timebase restarts on any pet or config write
  assign restart    = wr_config || wr_minutes || wr_seconds;
  assign active_count = count_unit_select ? minutes_countdown : seconds_countdown;

  bwd_tick #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_tick (
    .ref_clk_in (ref_clk_in),
    .resetn_in  (resetn_in),
    .clear_in   (restart),
    .tick_out   (tick)
  );

  always_comb begin
    next_config      = watchdog_config;
    next_minutes     = minutes_countdown;
    next_seconds     = seconds_countdown;
    next_sec_in_min  = sec_in_min;
    next_rst_count   = rst_count;
    next_board_reset = 1'b0;
    next_rdata       = 8'h00;
    next_rvalid      = ram_rd_in;
    if (wr_config) begin
      next_config = ram_wdata_in & BWD_CONFIG_MASK;
      next_sec_in_min = 6'h00;
    end
    if (countdown_run && tick && (active_count != 8'h00)) begin
      if (!count_unit_select) begin
        next_seconds = seconds_countdown - 8'h01;
      end else if (sec_in_min == BWD_SEC_PER_MIN - 6'h01) begin
        next_sec_in_min = 6'h00;
        next_minutes    = minutes_countdown - 8'h01;
      end else begin
        next_sec_in_min = sec_in_min + 6'h01;
      end
    end
    if (wr_minutes) begin
      next_minutes    = ram_wdata_in;
      next_sec_in_min = 6'h00;
    end
    if (wr_seconds) begin
      next_seconds = ram_wdata_in;
    end
    if (rst_count != 8'h00) begin
      next_rst_count   = rst_count - 8'h01;
      next_board_reset = 1'b1;
    end else if (countdown_run && (active_count == 8'h00) && !restart) begin
      next_rst_count   = 8'(RST_CYCLES - 1);
      next_board_reset = 1'b1;
      // run bit self-clears so the pulse fires once; unit bit kept
      next_config[BWD_BIT_RUN] = 1'b0;
    end
    next_active = next_config[BWD_BIT_RUN];
    case (ram_addr_in)
      BWD_OFS_CONFIG:  next_rdata = watchdog_config & BWD_CONFIG_MASK;
      BWD_OFS_MINUTES: next_rdata = minutes_countdown;
      BWD_OFS_SECONDS: next_rdata = seconds_countdown;
      default:         next_rdata = 8'h00;
    endcase
    if (!ram_rd_in) begin
      next_rdata = ram_rdata_out;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      watchdog_config      <= BWD_RESET_CONFIG;
      minutes_countdown    <= BWD_RESET_COUNT;
      seconds_countdown    <= BWD_RESET_COUNT;
      sec_in_min           <= BWD_RESET_SUBCOUNT;
      rst_count            <= BWD_RESET_PULSE;
      board_reset_out      <= 1'b0;
      ram_rdata_out        <= 8'h00;
      ram_rvalid_out       <= 1'b0;
      countdown_active_out <= 1'b0;
    end else begin
      watchdog_config      <= next_config;
      minutes_countdown    <= next_minutes;
      seconds_countdown    <= next_seconds;
      sec_in_min           <= next_sec_in_min;
      rst_count            <= next_rst_count;
      board_reset_out      <= next_board_reset;
      ram_rdata_out        <= next_rdata;
      ram_rvalid_out       <= next_rvalid;
      countdown_active_out <= next_active;
    end
  end

  // software order is assumed: unit, then count, then run

  sequence s_expire;
    countdown_run && (active_count == 8'h00) && !restart && (rst_count == 8'h00);
  endsequence

  AST_EXPIRE_RESET: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    s_expire |=> board_reset_out && !countdown_run)
    else $error("expiry did not pulse board reset");

  AST_NO_RESET_STOPPED: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    (!countdown_run && rst_count == 8'h00) |=> !board_reset_out)
    else $error("board reset while stopped");

  AST_SEC_DECREMENT: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    (countdown_run && !count_unit_select && tick && seconds_countdown != 8'h00 && !restart)
    |=> seconds_countdown == $past(seconds_countdown) - 8'h01)
    else $error("seconds counter did not decrement on tick");

  AST_HOLD_NO_TICK: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    (!tick && !restart) |=> $stable(seconds_countdown) && $stable(minutes_countdown))
    else $error("counter moved without tick");

  AST_PET_LOADS: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    wr_seconds |=> seconds_countdown == $past(ram_wdata_in))
    else $error("seconds pet not loaded");

  AST_MIN_PET_LOADS: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    wr_minutes |=> minutes_countdown == $past(ram_wdata_in) && sec_in_min == 6'h00)
    else $error("minutes pet not loaded");

  AST_CONFIG_MASK: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    (watchdog_config & ~BWD_CONFIG_MASK) == 8'h00)
    else $error("unused config bits set");

  AST_MIN_SLOW: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    (count_unit_select && sec_in_min != BWD_SEC_PER_MIN - 6'h01 && !restart)
    |=> $stable(minutes_countdown))
    else $error("minutes counter moved early");

  AST_READ_DATA: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    (ram_rd_in && ram_addr_in == BWD_OFS_SECONDS) |=> ram_rvalid_out
    && ram_rdata_out == $past(seconds_countdown))
    else $error("seconds readback wrong");

  AST_ACTIVE_FLAG: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    wr_config |=> countdown_active_out == $past(ram_wdata_in[BWD_BIT_RUN])
    || board_reset_out)
    else $error("run flag not reflected");

  sequence s_pulse_running;
    rst_count != 8'h00;
  endsequence

  sequence s_minute_wrap;
    countdown_run && count_unit_select && tick && (minutes_countdown != 8'h00)
    && (sec_in_min == BWD_SEC_PER_MIN - 6'h01) && !restart;
  endsequence

  AST_RESET_LOAD: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    s_expire |=> rst_count == 8'(RST_CYCLES - 1))
    else $error("board reset length not loaded");

  AST_RESET_HELD: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    s_pulse_running |=> board_reset_out && (rst_count == $past(rst_count) - 8'h01))
    else $error("board reset pulse cut short");

  AST_STOP_CLEARS: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    (wr_config && !ram_wdata_in[BWD_BIT_RUN]) |=> !countdown_run && !countdown_active_out)
    else $error("stop did not clear run");

  AST_STOPPED_HOLDS: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    (!countdown_run && !restart) |=> $stable(seconds_countdown) && $stable(minutes_countdown))
    else $error("counter moved while stopped");

  AST_MIN_DECREMENT: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    s_minute_wrap |=> (minutes_countdown == $past(minutes_countdown) - 8'h01)
    && (sec_in_min == 6'h00))
    else $error("minutes counter did not decrement");

  AST_READ_MINUTES: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    (ram_rd_in && ram_addr_in == BWD_OFS_MINUTES) |=> ram_rvalid_out
    && ram_rdata_out == $past(minutes_countdown))
    else $error("minutes readback wrong");
endmodule : bwd_watchdog
`default_nettype wire

// file: sim/bwd_watchdog_bench.sv
/*
  Self-checking bench for bwd_watchdog: byte register access, countdown in
  both units, petting, stop and the board reset pulse.
  Assumes short TICK_CYCLES and RST_CYCLES overrides and one 100 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
module bwd_watchdog_bench;
  import bwd_pkg::*;
  localparam int TK = 10;
  localparam int RC = 4;
  logic       ref_clk_in   = 1'b0;
  logic       resetn_in    = 1'b0;
  logic       ram_wr_in    = 1'b0;
  logic       ram_rd_in    = 1'b0;
  logic [7:0] ram_addr_in  = 8'h00;
  logic [7:0] ram_wdata_in = 8'h00;
  wire logic [7:0] ram_rdata_out;
  wire logic       ram_rvalid_out;
  wire logic       board_reset_out;
  wire logic       countdown_active_out;
  int n_fail   = 0;
  int compares = 0;
  int cyc_n    = 0;
  int t0;
  always #5 ref_clk_in = ~ref_clk_in;
  always @(posedge ref_clk_in) cyc_n <= cyc_n + 1;
  bwd_watchdog #(.TICK_CYCLES(TK), .RST_CYCLES(RC)) dut (
    .ref_clk_in           (ref_clk_in),
    .resetn_in            (resetn_in),
    .ram_addr_in          (ram_addr_in),
    .ram_wr_in            (ram_wr_in),
    .ram_rd_in            (ram_rd_in),
    .ram_wdata_in         (ram_wdata_in),
    .ram_rdata_out        (ram_rdata_out),
    .ram_rvalid_out       (ram_rvalid_out),
    .board_reset_out      (board_reset_out),
    .countdown_active_out (countdown_active_out)
  );
  task automatic end_of_test();
    $display("n_fail %0d compares %0d", n_fail, compares);
    if (n_fail == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_of_test
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string msg);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk8
  task automatic chk_rng(input int got, input int lo, input int hi, input string msg);
    compares++;
    if (got < lo || got > hi) begin
      n_fail++;
      $display("[FAIL] %0t %s %0d not in %0d..%0d", $time, msg, got, lo, hi);
    end
  endtask : chk_rng
  // caller sits just after a rising edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    ram_wr_in    = 1'b1;
    ram_addr_in  = a;
    ram_wdata_in = d;
    @(posedge ref_clk_in);
    #1 ram_wr_in = 1'b0;
    // idle edge so the next strobe is not raised in the same step
    @(posedge ref_clk_in);
    #1;
  endtask : wr
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    ram_rd_in   = 1'b1;
    ram_addr_in = a;
    @(posedge ref_clk_in);
    #1 ram_rd_in = 1'b0;
    chk8({7'h00, ram_rvalid_out}, 8'h01, "read strobe answer");
    chk8(ram_rdata_out, exp, "read data");
    // idle edge; answer strobe must be gone, data must hold
    @(posedge ref_clk_in);
    #1 chk8({7'h00, ram_rvalid_out}, 8'h00, "read answer held too long");
    chk8(ram_rdata_out, exp, "read data not held");
  endtask : rd_chk
  task automatic quiet(input int n);
    repeat (n) begin
      @(posedge ref_clk_in);
      #1 chk8({7'h00, board_reset_out}, 8'h00, "unexpected board reset");
    end
  endtask : quiet
  // wait for the reset pulse, check its moment and its length
  task automatic expire(input int lo, input int hi);
    int j;
    while (board_reset_out !== 1'b1 && cyc_n - t0 <= hi + 4) begin
      @(posedge ref_clk_in);
      #1;
    end
    if (board_reset_out !== 1'b1) begin
      n_fail++;
      $display("[FAIL] %0t board reset never came", $time);
      end_of_test();
    end else begin
      chk_rng(cyc_n - t0, lo, hi, "expiry moment");
      j = 0;
      while (board_reset_out === 1'b1 && j < 100) begin
        @(posedge ref_clk_in);
        #1 j++;
      end
      chk_rng(j, RC, RC, "board reset length");
      chk8({7'h00, countdown_active_out}, 8'h00, "run after expiry");
    end
  endtask : expire
  initial begin
    repeat (12) @(posedge ref_clk_in);
    #1 resetn_in = 1'b1;
    chk8({6'h00, board_reset_out, countdown_active_out}, 8'h00, "outputs at reset");
    rd_chk(BWD_OFS_CONFIG, 8'h00);
    rd_chk(BWD_OFS_MINUTES, 8'h00);
    rd_chk(BWD_OFS_SECONDS, 8'h00);
    wr(BWD_OFS_CONFIG, 8'hfe);
    rd_chk(BWD_OFS_CONFIG, 8'h02);
    chk8({7'h00, countdown_active_out}, 8'h00, "run stays off");
    wr(8'h09, 8'h55);
    rd_chk(8'h09, 8'h00);
    wr(BWD_OFS_SECONDS, 8'hff);
    rd_chk(BWD_OFS_SECONDS, 8'hff);
    wr(BWD_OFS_MINUTES, 8'hff);
    rd_chk(BWD_OFS_MINUTES, 8'hff);
    // run with the selected counter already at zero
    wr(BWD_OFS_MINUTES, 8'h00);
    wr(BWD_OFS_CONFIG, 8'h03);
    t0 = cyc_n;
    expire(0, 2);
    rd_chk(BWD_OFS_CONFIG, 8'h02);
    // seconds countdown from three
    wr(BWD_OFS_CONFIG, 8'h00);
    wr(BWD_OFS_SECONDS, 8'h03);
    wr(BWD_OFS_CONFIG, 8'h01);
    t0 = cyc_n;
    chk8({7'h00, countdown_active_out}, 8'h01, "run on");
    quiet(TK + TK / 2);
    rd_chk(BWD_OFS_SECONDS, 8'h02);
    expire(3 * TK - 2, 3 * TK + 4);
    // petting holds off the reset, then stop
    wr(BWD_OFS_SECONDS, 8'h03);
    wr(BWD_OFS_CONFIG, 8'h01);
    repeat (4) begin
      quiet(2 * TK);
      wr(BWD_OFS_SECONDS, 8'h03);
    end
    wr(BWD_OFS_CONFIG, 8'h00);
    quiet(5 * TK);
    chk8({7'h00, countdown_active_out}, 8'h00, "run off");
    // minutes countdown of one; seconds counter left at three
    wr(BWD_OFS_CONFIG, 8'h02);
    wr(BWD_OFS_MINUTES, 8'h01);
    wr(BWD_OFS_CONFIG, 8'h03);
    t0 = cyc_n;
    expire(60 * TK - 2, 60 * TK + 4);
    end_of_test();
  end
endmodule : bwd_watchdog_bench
`default_nettype wire
